// *** rtl/macro_cmd_params.svh ***
// register offsets, field positions, reset values and codes of the macro command unit
`ifndef MACRO_CMD_PARAMS_SVH
`define MACRO_CMD_PARAMS_SVH
// --------------------------------------------------------------------------
// register indices (printed offsets; byte address is four times the index)
// --------------------------------------------------------------------------
`define IDX_ARG3        16'h05bc
`define IDX_ARG2        16'h05be
`define IDX_ARG1        16'h05c0
`define IDX_CMD         16'h05c2
`define IDX_CTRL        16'h0600
`define IDX_CAM_LIMIT   16'h0601
`define IDX_CAM_PULSES  16'h0602
`define IDX_IRQ_STATUS  16'h0603
`define IDX_IRQ_MASK    16'h0604
// --------------------------------------------------------------------------
// reset values and codes
// --------------------------------------------------------------------------
`define CMD_RESET       16'h0100
`define CMD_MAX         16'h0999
`define CODE_SYNC_OFF   16'h0000
`define CODE_SYNC_ON    16'h0001
`define CODE_CAM_PULSE  16'h0005
`define OK_NIBBLE       4'h1
`define FAIL_ILLEGAL    16'hf001
`define FAIL_CAPTURE_ON 16'hf002
`define FAIL_COMPARE_ON 16'hf003
`define FAIL_ADDR_CLASH 16'hf004
`define FAIL_CAM_LIMIT  16'hf005
// --------------------------------------------------------------------------
// control register fields
// --------------------------------------------------------------------------
`define CTRL_CAPTURE    0
`define CTRL_COMPARE    1
`define CTRL_SYNC       2
`define CTRL_SRC_LO     4
`define CTRL_SRC_HI     7
// --------------------------------------------------------------------------
// interrupt status bits
// --------------------------------------------------------------------------
`define IRQ_DONE        0
`define IRQ_FAIL        1
`endif

// *** rtl/macro_cmd_pkg.sv ***
// types of the macro command unit
package macro_cmd_pkg;
  typedef enum logic [1:0] {
    st_idle,
    st_exec
  } state_e;
endpackage

// *** rtl/motion_macro_command_unit.sv ***
// macro command interpreter with argument, control and interrupt registers
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "macro_cmd_params.svh"
// Notes on behaviour
// - writing a code up to 0999h to the command register starts its execution
// - success reads back the executed code with top nibble 1
// - a failed command reads back F in the top nibble plus a cause
// - an illegal code reads back an F failure value and does nothing
// - code 0000h stops sync correction of the capture sync axis
// - code 0000h also turns capture and compare off
// - code 0000h keeps capture source selection, which stays writable
// - code 0001h starts sync correction
// - code 0001h takes argument 1 as first compare point coordinate
// - successful 0001h turns on capture, compare and sync correction
// - 0001h fails with F002h when capture is already on
// - 0001h fails with F003h when compare is already on
// - 0001h fails with F004h when capture and compare array addresses clash
// - code 0005h writes the master pulses per cam cycle into argument 2
// - code 0005h fails with F005h when that count exceeds the cam limit
// - argument registers hold full signed 32-bit values
module motion_macro_command_unit #(
  parameter int ADDR_W = 16
) (
  // clock, reset, enable
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  // engine status inputs
  input  wire logic              array_clash,
  input  wire logic [31:0]       cam_cycle_pulses,
  // engine controls
  output logic                   capture_en,
  output logic                   compare_en,
  output logic                   sync_corr_en,
  output logic      [3:0]        capture_src,
  output logic      [31:0]       first_compare_point,
  // interrupt
  output logic                   irq
);

  // ------------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------------
  logic signed [31:0]    arg1_q, arg2_q, arg3_q;
  logic [15:0]           cmd_q;
  logic [15:0]           pend_q;
  logic [31:0]           limit_q;
  logic [1:0]            stat_q, mask_q;
  macro_cmd_pkg::state_e state_q;
  logic                  done_ev, fail_ev;
  logic [15:0]           result_d;
  logic                  cam_wr;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a == idx[ADDR_W-1:0]);
  endfunction

  // ------------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------------
  always_comb begin
    result_d = {`OK_NIBBLE, pend_q[11:0]};
    cam_wr   = 1'b0;
    case (pend_q)
      `CODE_SYNC_OFF: result_d = {`OK_NIBBLE, pend_q[11:0]};
      `CODE_SYNC_ON: begin
        if (capture_en)
          result_d = `FAIL_CAPTURE_ON;
        else if (compare_en)
          result_d = `FAIL_COMPARE_ON;
        else if (array_clash)
          result_d = `FAIL_ADDR_CLASH;
      end
      `CODE_CAM_PULSE: begin
        if (cam_cycle_pulses > limit_q)
          result_d = `FAIL_CAM_LIMIT;
        else
          cam_wr = 1'b1;
      end
      default: result_d = `FAIL_ILLEGAL;
    endcase
  end

  // ------------------------------------------------------------------------
  // sequencer: one cycle to take, one to execute
  // ------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= macro_cmd_pkg::st_idle;
      pend_q  <= 16'h0000;
    end else if (clk_en) begin
      case (state_q)
        macro_cmd_pkg::st_idle: begin
          if (wr && hit(addr, `IDX_CMD)) begin
            pend_q  <= wdata[15:0];
            state_q <= macro_cmd_pkg::st_exec;
          end
        end
        macro_cmd_pkg::st_exec: state_q <= macro_cmd_pkg::st_idle;
        default: state_q <= macro_cmd_pkg::st_idle;
      endcase
    end
  end

  assign done_ev = (state_q == macro_cmd_pkg::st_exec) && (result_d[15:12] == `OK_NIBBLE);
  assign fail_ev = (state_q == macro_cmd_pkg::st_exec) && (result_d[15:12] != `OK_NIBBLE);

  // command register: result holds until the next command write
  always_ff @(posedge clock) begin
    if (rst)
      cmd_q <= `CMD_RESET;
    else if (clk_en && state_q == macro_cmd_pkg::st_exec)
      cmd_q <= result_d;
  end

  // ------------------------------------------------------------------------
  // arguments
  // ------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      arg1_q <= 32'sh0;
      arg2_q <= 32'sh0;
      arg3_q <= 32'sh0;
    end else if (clk_en) begin
      if (wr && hit(addr, `IDX_ARG1))
        arg1_q <= wdata;
      if (wr && hit(addr, `IDX_ARG3))
        arg3_q <= wdata;
      if (cam_wr && state_q == macro_cmd_pkg::st_exec)
        arg2_q <= cam_cycle_pulses;
      else if (wr && hit(addr, `IDX_ARG2))
        arg2_q <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst)
      limit_q <= 32'h0;
    else if (clk_en && wr && hit(addr, `IDX_CAM_LIMIT))
      limit_q <= wdata;
  end

  // ------------------------------------------------------------------------
  // engine controls
  // ------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      capture_en          <= 1'b0;
      compare_en          <= 1'b0;
      sync_corr_en        <= 1'b0;
      capture_src         <= 4'h0;
      first_compare_point <= 32'h0;
    end else if (clk_en) begin
      // software may still drive capture and compare directly
      if (wr && hit(addr, `IDX_CTRL)) begin
        capture_en   <= wdata[`CTRL_CAPTURE];
        compare_en   <= wdata[`CTRL_COMPARE];
        sync_corr_en <= wdata[`CTRL_SYNC];
        capture_src  <= wdata[`CTRL_SRC_HI:`CTRL_SRC_LO];
      end
      if (state_q == macro_cmd_pkg::st_exec && pend_q == `CODE_SYNC_OFF) begin
        sync_corr_en <= 1'b0;
        capture_en   <= 1'b0;
        compare_en   <= 1'b0;
      end
      if (done_ev && pend_q == `CODE_SYNC_ON) begin
        sync_corr_en        <= 1'b1;
        capture_en          <= 1'b1;
        compare_en          <= 1'b1;
        first_compare_point <= arg1_q;
      end
    end
  end

  // ------------------------------------------------------------------------
  // interrupts: set wins over read-clear
  // ------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      stat_q <= 2'h0;
      mask_q <= 2'h0;
    end else if (clk_en) begin
      if (wr && hit(addr, `IDX_IRQ_MASK))
        mask_q <= wdata[1:0];
      stat_q <= ((rd && hit(addr, `IDX_IRQ_STATUS)) ? 2'h0 : stat_q) | {fail_ev, done_ev};
    end
  end

  always_ff @(posedge clock) begin
    if (rst)
      irq <= 1'b0;
    else if (clk_en)
      irq <= |(stat_q & mask_q);
  end

  // ------------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst)
      rdata <= 32'h0;
    else if (clk_en) begin
      rdata <= 32'h0;
      if (rd) begin
        if (hit(addr, `IDX_ARG1))
          rdata <= arg1_q;
        else if (hit(addr, `IDX_ARG2))
          rdata <= arg2_q;
        else if (hit(addr, `IDX_ARG3))
          rdata <= arg3_q;
        else if (hit(addr, `IDX_CMD))
          rdata <= {16'h0, cmd_q};
        else if (hit(addr, `IDX_CTRL))
          rdata <= {24'h0, capture_src, 1'b0, sync_corr_en, compare_en, capture_en};
        else if (hit(addr, `IDX_CAM_LIMIT))
          rdata <= limit_q;
        else if (hit(addr, `IDX_CAM_PULSES))
          rdata <= cam_cycle_pulses;
        else if (hit(addr, `IDX_IRQ_STATUS))
          rdata <= {30'h0, stat_q};
        else if (hit(addr, `IDX_IRQ_MASK))
          rdata <= {30'h0, mask_q};
      end
    end
  end

endmodule

// *** verif/motion_macro_command_unit_assertions.sv ***
// concurrent checks of the macro command unit, bound to its ports
`timescale 1ns/1ps
`include "macro_cmd_params.svh"
module motion_macro_command_unit_checker #(
  parameter int ADDR_W = 16
) (
  // clock, reset and enable
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              clk_en,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0]       wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [31:0]       rdata,
  // engine side
  input wire logic              array_clash,
  input wire logic [31:0]       cam_cycle_pulses,
  input wire logic              capture_en,
  input wire logic              compare_en,
  input wire logic              sync_corr_en,
  input wire logic [3:0]        capture_src,
  input wire logic [31:0]       first_compare_point,
  input wire logic              irq
);
  // --------------------------------------------------------------------------
  // shadow of arguments 1 and 2, the cam limit and a pending cam pulse command
  // --------------------------------------------------------------------------
  logic [15:0] code;
  logic        cmd_go;
  logic        p5_q;
  logic [31:0] arg1_q;
  logic [31:0] arg2_q;
  logic [31:0] lim_q;
  assign code   = wdata[15:0];
  assign cmd_go = clk_en && wr && addr == ADDR_W'(`IDX_CMD);
  always_ff @(posedge clock) begin
    if (rst) begin
      p5_q   <= 1'b0;
      arg1_q <= 32'h0;
      arg2_q <= 32'h0;
      lim_q  <= 32'h0;
    end else if (clk_en) begin
      p5_q <= cmd_go && code == `CODE_CAM_PULSE;
      if (wr && addr == ADDR_W'(`IDX_ARG1)) arg1_q <= wdata;
      if (wr && addr == ADDR_W'(`IDX_CAM_LIMIT)) lim_q <= wdata;
      // the result of a cam pulse command beats a host write in the same cycle
      if (p5_q && cam_cycle_pulses <= lim_q) arg2_q <= cam_cycle_pulses;
      else if (wr && addr == ADDR_W'(`IDX_ARG2)) arg2_q <= wdata;
    end
  end
  // --------------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_off;
    cmd_go && code == `CODE_SYNC_OFF |-> ##2 !(sync_corr_en || capture_en || compare_en);
  endproperty
  property p_src;
    cmd_go && code == `CODE_SYNC_OFF |-> ##2 capture_src == $past(capture_src, 2);
  endproperty
  property p_on;
    cmd_go && code == `CODE_SYNC_ON && !capture_en && !compare_en && !array_clash
      |-> ##2 capture_en && compare_en && sync_corr_en && first_compare_point == arg1_q;
  endproperty
  property p_refuse;
    cmd_go && code == `CODE_SYNC_ON && (capture_en || compare_en || array_clash)
      |-> ##2 $stable(sync_corr_en) && first_compare_point == $past(first_compare_point, 2);
  endproperty
  property p_illegal;
    cmd_go && !(code inside {`CODE_SYNC_OFF, `CODE_SYNC_ON, `CODE_CAM_PULSE})
      |-> ##2 $stable({capture_en, compare_en, sync_corr_en, capture_src});
  endproperty
  property p_arg1;
    clk_en && rd && addr == ADDR_W'(`IDX_ARG1) |=> rdata == arg1_q;
  endproperty
  property p_arg2;
    clk_en && rd && addr == ADDR_W'(`IDX_ARG2) |=> rdata == arg2_q;
  endproperty
  property p_rd_idle;
    clk_en && !rd |=> rdata == 32'h0;
  endproperty
  a_off: assert property (p_off) else $error("stop command left a control on");
  a_src: assert property (p_src) else $error("capture source moved");
  a_on: assert property (p_on) else $error("start command incomplete");
  a_refuse: assert property (p_refuse) else $error("refused start acted");
  a_illegal: assert property (p_illegal) else $error("illegal code acted");
  a_arg1: assert property (p_arg1) else $error("argument 1 readback wrong");
  a_arg2: assert property (p_arg2) else $error("argument 2 readback wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  c_on: cover property (cmd_go && code == `CODE_SYNC_ON ##2 sync_corr_en);
  c_cam: cover property (p5_q);
  c_irq: cover property (irq);
endmodule
bind motion_macro_command_unit motion_macro_command_unit_checker #(.ADDR_W(ADDR_W)) chk (
  .clock(clock), .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .array_clash(array_clash), .cam_cycle_pulses(cam_cycle_pulses),
  .capture_en(capture_en), .compare_en(compare_en), .sync_corr_en(sync_corr_en),
  .capture_src(capture_src), .first_compare_point(first_compare_point), .irq(irq));

// *** verif/motion_macro_command_unit_test.sv ***
// self-checking bench of the macro command unit
`timescale 1ns/1ps
`include "macro_cmd_params.svh"
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module motion_macro_command_unit_test;
  logic        clock = 1'b0, rst = 1'b1, clk_en = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        array_clash = 1'b0, m_cap = 1'b0, m_cmp = 1'b0, m_clash = 1'b0;
  logic        capture_en, compare_en, sync_corr_en, irq;
  logic [3:0]  capture_src;
  logic [15:0] addr = 16'h0, e;
  logic [31:0] wdata = 32'h0, cam_cycle_pulses = 32'h0, rdata, first_compare_point;
  logic [31:0] v, a1, a2, m_lim;
  int          bad_count = 0, checks_done = 0;
  motion_macro_command_unit DUT (.clock(clock), .rst(rst), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .array_clash(array_clash),
    .cam_cycle_pulses(cam_cycle_pulses), .capture_en(capture_en), .compare_en(compare_en),
    .sync_corr_en(sync_corr_en), .capture_src(capture_src),
    .first_compare_point(first_compare_point), .irq(irq));
  initial forever #50 clock = ~clock;
  // --------------------------------------------------------------------------
  // bus cycles and expectations
  // --------------------------------------------------------------------------
  // every access ends with an idle cycle, which also spaces command writes
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock);
    v = rdata;
  endtask
  function automatic logic [15:0] exp_res(input logic [15:0] c);
    if (c == `CODE_CAM_PULSE && cam_cycle_pulses > m_lim) return `FAIL_CAM_LIMIT;
    if (c == `CODE_SYNC_ON && m_cap) return `FAIL_CAPTURE_ON;
    if (c == `CODE_SYNC_ON && m_cmp) return `FAIL_COMPARE_ON;
    if (c == `CODE_SYNC_ON && m_clash) return `FAIL_ADDR_CLASH;
    if (!(c inside {`CODE_SYNC_OFF, `CODE_SYNC_ON, `CODE_CAM_PULSE})) return `FAIL_ILLEGAL;
    return {`OK_NIBBLE, c[11:0]};
  endfunction
  task automatic cmd(input logic [15:0] c);
    e = exp_res(c);
    bus(1'b1, `IDX_CMD, {16'h0, c});
    bus(1'b0, `IDX_CMD, 32'h0);
    `CHK("result", {16'h0, e}, v)
    if (c == `CODE_SYNC_OFF) {m_cap, m_cmp} = 2'b00;
    if (e == 16'h1001) {m_cap, m_cmp} = 2'b11;
    `CHK("capture", m_cap, capture_en)
    `CHK("compare", m_cmp, compare_en)
  endtask
  task automatic ctrl(input logic [7:0] d);
    bus(1'b1, `IDX_CTRL, {24'h0, d});
    {m_cmp, m_cap} = d[1:0];
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hfc24));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, `IDX_CMD, 32'h0);
    `CHK("cmd reset", 32'h100, v)
    for (int i = 0; i < 3; i++) begin
      a1 = i == 0 ? 32'h80000000 : i == 1 ? 32'h7fffffff : $urandom;
      bus(1'b1, `IDX_ARG3 + 16'(2 * i), a1);
      bus(1'b0, `IDX_ARG3 + 16'(2 * i), 32'h0);
      `CHK("argument", a1, v)
    end
    bus(1'b1, `IDX_IRQ_MASK, 32'h3);
    ctrl(8'ha0);
    cmd(`CODE_SYNC_OFF);
    `CHK("src kept", 4'ha, capture_src)
    `CHK("irq on", 1'b1, irq)
    bus(1'b0, `IDX_IRQ_STATUS, 32'h0);
    `CHK("status", 32'h1, v)
    ctrl(8'h50);
    `CHK("irq cleared", 1'b0, irq)
    `CHK("src write", 4'h5, capture_src)
    // arguments and control are loaded before the start command is written
    cmd(`CODE_SYNC_ON);
    `CHK("point", a1, first_compare_point)
    `CHK("sync", 1'b1, sync_corr_en)
    cmd(`CODE_SYNC_ON);
    ctrl(8'h02);
    cmd(`CODE_SYNC_ON);
    ctrl(8'h00);
    // the model copy avoids reading the pin before its update has landed
    array_clash <= 1'b1;
    m_clash = 1'b1;
    cmd(`CODE_SYNC_ON);
    array_clash <= 1'b0;
    m_clash = 1'b0;
    bus(1'b1, `IDX_IRQ_MASK, 32'h0);
    for (int i = 0; i < 6; i++) cmd(i == 0 ? 16'h0002 : i == 1 ? `CMD_MAX :
      16'h0006 + 16'($urandom % 32'h993));
    `CHK("irq masked", 1'b0, irq)
    a2 = 32'h7fffffff;
    for (int i = 0; i < 6; i++) begin
      m_lim = $urandom;
      cam_cycle_pulses <= i == 0 ? m_lim : i == 1 ? m_lim + 32'h1 : $urandom;
      bus(1'b1, `IDX_CAM_LIMIT, m_lim);
      cmd(`CODE_CAM_PULSE);
      a2 = e == `FAIL_CAM_LIMIT ? a2 : cam_cycle_pulses;
      bus(1'b0, `IDX_ARG2, 32'h0);
      `CHK("pulses", a2, v)
      bus(1'b0, `IDX_CMD, 32'h0);
      `CHK("result held", {16'h0, e}, v)
    end
    clk_en <= 1'b0;
    bus(1'b1, `IDX_ARG3, 32'h5a5a5a5a);
    clk_en <= 1'b1;
    bus(1'b0, `IDX_ARG3, 32'h0);
    `CHK("frozen", 32'h80000000, v)
    wrap_up();
  end
endmodule
